// ---- ipr_defines.vh ----
`ifndef IPR_DEFINES_VH
`define IPR_DEFINES_VH

// Bus geometry
`define IPR_ADDR_W        8
`define IPR_DATA_W        32
`define IPR_STRB_W        4
`define IPR_REG_W         16

// Register byte offsets
`define IPR_OFS_ADC_UART1 8'h00
`define IPR_OFS_CHG_CMP   8'h04
`define IPR_OFS_EXT1      8'h08
`define IPR_OFS_TMR4_OC   8'h0C
`define IPR_OFS_U2_T5     8'h10
`define IPR_OFS_REQ_STAT  8'h14
`define IPR_OFS_EN_STAT   8'h18

// Priority field geometry and codes
`define IPR_FIELD_W       3
`define IPR_FIELD_RST     3'h4
`define IPR_LVL_OFF       3'h0
`define IPR_LVL_MIN       3'h1
`define IPR_LVL_MAX       3'h7
`define IPR_NUM_SRC       14

// Field low-bit positions inside their registers
`define IPR_LSB_CONV_DONE 4
`define IPR_LSB_SER1_SEND 0
`define IPR_LSB_PIN_CHG   12
`define IPR_LSB_COMPARE   8
`define IPR_LSB_TW1_MST   4
`define IPR_LSB_TW1_SLV   0
`define IPR_LSB_EXT1      0
`define IPR_LSB_TMR4      12
`define IPR_LSB_OC4       8
`define IPR_LSB_OC3       4
`define IPR_LSB_SER2_SEND 12
`define IPR_LSB_SER2_RECV 8
`define IPR_LSB_EXT2      4
`define IPR_LSB_TMR5      0

// AXI responses
`define IPR_RESP_OKAY     2'h0
`define IPR_RESP_SLVERR   2'h2

`endif

// ---- ipr_field.v ----
`timescale 1ns/10ps
`default_nettype none
`include "ipr_defines.vh"

module ipr_field #(
    parameter [`IPR_FIELD_W-1:0] RST = `IPR_FIELD_RST
) (
    input  wire                    aclk,
    input  wire                    aresetn,
    input  wire                    wr_en,
    input  wire [`IPR_FIELD_W-1:0] wr_data,
    output reg  [`IPR_FIELD_W-1:0] level_q
);

    // RL5 - Level four at reset
    always @(posedge aclk) begin
        if (!aresetn) begin
            level_q <= RST;
        end else if (wr_en) begin
            level_q <= wr_data;
        end
    end

endmodule
`default_nettype wire

// ---- ipr_req_gate.v ----
`timescale 1ns/10ps
`default_nettype none
`include "ipr_defines.vh"

module ipr_req_gate (
    input  wire                    aclk,
    input  wire                    aresetn,
    input  wire [`IPR_FIELD_W-1:0] level,
    input  wire                    req_in,
    output wire                    enabled,
    output reg                     req_q
);

    // RL2 - Zero blocks requests
    assign enabled = (level != `IPR_LVL_OFF);

    always @(posedge aclk) begin
        if (!aresetn) begin
            req_q <= 1'b0;
        end else begin
            req_q <= req_in & enabled;
        end
    end

endmodule
`default_nettype wire

// ---- ipr_regs.v ----
// Notes on behaviour
// RL1 - Code 111 means level seven, highest
// RL2 - Code 000 disables the source entirely
// RL3 - Code 001 is level one, ascending
// RL4 - Unused bits ignore writes, read zero
// RL5 - Fields reset to 100, stay writable
// RL6 - Reg0: converter done bits 6-4
// RL7 - Reg0: serial one send bits 2-0
// RL8 - Reg1: pin change 14-12, comparator 10-8
// RL9 - Reg1: two-wire master 6-4, slave 2-0
// RL10 - Reg2: external pin one bits 2-0
// RL11 - Reg3: timer four bits 14-12
// RL12 - Reg3: compare four bits 10-8
// RL13 - Reg3: compare three bits 6-4
// RL14 - Reg4: serial two send, receive
// RL15 - Reg4: external pin two, timer five
`timescale 1ns/10ps
`default_nettype none
`include "ipr_defines.vh"

module ipr_regs (
    input  wire                     aclk,
    input  wire                     aresetn,
    input  wire [`IPR_ADDR_W-1:0]   s_axi_awaddr,
    input  wire [2:0]               s_axi_awprot,
    input  wire                     s_axi_awvalid,
    output wire                     s_axi_awready,
    input  wire [`IPR_DATA_W-1:0]   s_axi_wdata,
    input  wire [`IPR_STRB_W-1:0]   s_axi_wstrb,
    input  wire                     s_axi_wvalid,
    output wire                     s_axi_wready,
    output reg  [1:0]               s_axi_bresp,
    output reg                      s_axi_bvalid,
    input  wire                     s_axi_bready,
    input  wire [`IPR_ADDR_W-1:0]   s_axi_araddr,
    input  wire [2:0]               s_axi_arprot,
    input  wire                     s_axi_arvalid,
    output wire                     s_axi_arready,
    output reg  [`IPR_DATA_W-1:0]   s_axi_rdata,
    output reg  [1:0]               s_axi_rresp,
    output reg                      s_axi_rvalid,
    input  wire                     s_axi_rready,
    input  wire [`IPR_NUM_SRC-1:0]  src_req_in,
    output wire [`IPR_NUM_SRC-1:0]  src_req_q,
    output wire [`IPR_FIELD_W-1:0]  converter_done_level,
    output wire [`IPR_FIELD_W-1:0]  serial_one_send_level,
    output wire [`IPR_FIELD_W-1:0]  pin_change_level,
    output wire [`IPR_FIELD_W-1:0]  comparator_level,
    output wire [`IPR_FIELD_W-1:0]  twowire_one_master_level,
    output wire [`IPR_FIELD_W-1:0]  twowire_one_slave_level,
    output wire [`IPR_FIELD_W-1:0]  ext_pin_one_level,
    output wire [`IPR_FIELD_W-1:0]  timer_four_level,
    output wire [`IPR_FIELD_W-1:0]  compare_four_level,
    output wire [`IPR_FIELD_W-1:0]  compare_three_level,
    output wire [`IPR_FIELD_W-1:0]  serial_two_send_level,
    output wire [`IPR_FIELD_W-1:0]  serial_two_receive_level,
    output wire [`IPR_FIELD_W-1:0]  ext_pin_two_level,
    output wire [`IPR_FIELD_W-1:0]  timer_five_level
);

    localparam NSRC = `IPR_NUM_SRC;
    localparam FW   = `IPR_FIELD_W;
    localparam NREG = 5;

    // Register index of each source
    function integer src_reg;
        input integer s;
        begin
            case (s)
                0, 1:       src_reg = 0;
                2, 3, 4, 5: src_reg = 1;
                6:          src_reg = 2;
                7, 8, 9:    src_reg = 3;
                default:    src_reg = 4;
            endcase
        end
    endfunction

    // Field low bit of each source
    function integer src_lsb;
        input integer s;
        begin
            case (s)
                0:       src_lsb = `IPR_LSB_CONV_DONE;
                1:       src_lsb = `IPR_LSB_SER1_SEND;
                2:       src_lsb = `IPR_LSB_PIN_CHG;
                3:       src_lsb = `IPR_LSB_COMPARE;
                4:       src_lsb = `IPR_LSB_TW1_MST;
                5:       src_lsb = `IPR_LSB_TW1_SLV;
                6:       src_lsb = `IPR_LSB_EXT1;
                7:       src_lsb = `IPR_LSB_TMR4;
                8:       src_lsb = `IPR_LSB_OC4;
                9:       src_lsb = `IPR_LSB_OC3;
                10:      src_lsb = `IPR_LSB_SER2_SEND;
                11:      src_lsb = `IPR_LSB_SER2_RECV;
                12:      src_lsb = `IPR_LSB_EXT2;
                default: src_lsb = `IPR_LSB_TMR5;
            endcase
        end
    endfunction

    reg                      aw_held_q;
    reg  [`IPR_ADDR_W-1:0]   aw_addr_q;
    reg                      w_held_q;
    reg  [`IPR_DATA_W-1:0]   w_data_q;
    reg  [`IPR_STRB_W-1:0]   w_strb_q;
    wire                     aw_fire;
    wire                     w_fire;
    wire                     ar_fire;
    wire                     wr_go;
    wire [`IPR_ADDR_W-1:0]   wr_word;
    wire [`IPR_ADDR_W-1:0]   rd_word;
    reg  [NREG-1:0]          wr_hit;
    reg                      wr_mapped;
    reg  [`IPR_REG_W-1:0]    rd_val;
    reg                      rd_mapped;
    wire [NSRC*FW-1:0]       lvl;
    wire [NSRC-1:0]          src_en;
    wire [`IPR_REG_W-1:0]    adc_uart1_tx_priority;
    wire [`IPR_REG_W-1:0]    change_cmp_i2c1_priority;
    wire [`IPR_REG_W-1:0]    ext_pin1_priority;
    wire [`IPR_REG_W-1:0]    timer4_compare34_priority;
    wire [`IPR_REG_W-1:0]    uart2_ext2_timer5_priority;

    // Write channel: address and data taken in either order
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
    assign aw_fire       = s_axi_awvalid && s_axi_awready;
    assign w_fire        = s_axi_wvalid && s_axi_wready;
    assign wr_go         = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wr_word       = {aw_addr_q[`IPR_ADDR_W-1:2], 2'h0};

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= {`IPR_ADDR_W{1'b0}};
        end else if (aw_fire) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held_q <= 1'b0;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            w_data_q <= {`IPR_DATA_W{1'b0}};
            w_strb_q <= {`IPR_STRB_W{1'b0}};
        end else if (w_fire) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held_q <= 1'b0;
        end
    end

    // Write address decode
    always @* begin
        wr_hit    = {NREG{1'b0}};
        wr_mapped = 1'b1;
        case (wr_word)
            `IPR_OFS_ADC_UART1: wr_hit[0] = 1'b1;
            `IPR_OFS_CHG_CMP:   wr_hit[1] = 1'b1;
            `IPR_OFS_EXT1:      wr_hit[2] = 1'b1;
            `IPR_OFS_TMR4_OC:   wr_hit[3] = 1'b1;
            `IPR_OFS_U2_T5:     wr_hit[4] = 1'b1;
            `IPR_OFS_REQ_STAT:  wr_mapped = 1'b1;
            `IPR_OFS_EN_STAT:   wr_mapped = 1'b1;
            default:            wr_mapped = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `IPR_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? `IPR_RESP_OKAY : `IPR_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // One storage field and one request gate per source
    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi = gi + 1) begin : g_src
            localparam integer R = src_reg(gi);
            localparam integer L = src_lsb(gi);
            wire field_we;

            // RL4 - Only field bits written
            assign field_we = wr_go && wr_hit[R] && w_strb_q[L/8];

            ipr_field #(
                .RST     (`IPR_FIELD_RST)
            ) u_field (
                .aclk    (aclk),
                .aresetn (aresetn),
                .wr_en   (field_we),
                .wr_data (w_data_q[L+FW-1:L]),
                .level_q (lvl[gi*FW +: FW])
            );

            ipr_req_gate u_gate (
                .aclk    (aclk),
                .aresetn (aresetn),
                .level   (lvl[gi*FW +: FW]),
                .req_in  (src_req_in[gi]),
                .enabled (src_en[gi]),
                .req_q   (src_req_q[gi])
            );
        end
    endgenerate

    // RL1 - Code equals level
    // RL3 - Ascending binary levels
    assign converter_done_level     = lvl[0*FW +: FW];
    assign serial_one_send_level    = lvl[1*FW +: FW];
    assign pin_change_level         = lvl[2*FW +: FW];
    assign comparator_level         = lvl[3*FW +: FW];
    assign twowire_one_master_level = lvl[4*FW +: FW];
    assign twowire_one_slave_level  = lvl[5*FW +: FW];
    assign ext_pin_one_level        = lvl[6*FW +: FW];
    assign timer_four_level         = lvl[7*FW +: FW];
    assign compare_four_level       = lvl[8*FW +: FW];
    assign compare_three_level      = lvl[9*FW +: FW];
    assign serial_two_send_level    = lvl[10*FW +: FW];
    assign serial_two_receive_level = lvl[11*FW +: FW];
    assign ext_pin_two_level        = lvl[12*FW +: FW];
    assign timer_five_level         = lvl[13*FW +: FW];

    // RL6 - Converter done field
    // RL7 - Serial one send field
    assign adc_uart1_tx_priority = {9'h000, converter_done_level, 1'h0,
                                    serial_one_send_level};

    // RL8 - Pin change, comparator
    // RL9 - Two-wire master, slave
    assign change_cmp_i2c1_priority = {1'h0, pin_change_level,
                                       1'h0, comparator_level,
                                       1'h0, twowire_one_master_level,
                                       1'h0, twowire_one_slave_level};

    // RL10 - External pin one
    assign ext_pin1_priority = {13'h0000, ext_pin_one_level};

    // RL11 - Timer four field
    // RL12 - Compare four field
    // RL13 - Compare three field
    assign timer4_compare34_priority = {1'h0, timer_four_level,
                                        1'h0, compare_four_level,
                                        1'h0, compare_three_level,
                                        4'h0};

    // RL14 - Serial two fields
    // RL15 - External two, timer five
    assign uart2_ext2_timer5_priority = {1'h0, serial_two_send_level,
                                         1'h0, serial_two_receive_level,
                                         1'h0, ext_pin_two_level,
                                         1'h0, timer_five_level};

    // Read channel
    assign s_axi_arready = !s_axi_rvalid;
    assign ar_fire       = s_axi_arvalid && s_axi_arready;
    assign rd_word       = {s_axi_araddr[`IPR_ADDR_W-1:2], 2'h0};

    // RL4 - Unused bits read zero
    always @* begin
        rd_val    = {`IPR_REG_W{1'b0}};
        rd_mapped = 1'b1;
        case (rd_word)
            `IPR_OFS_ADC_UART1: rd_val = adc_uart1_tx_priority;
            `IPR_OFS_CHG_CMP:   rd_val = change_cmp_i2c1_priority;
            `IPR_OFS_EXT1:      rd_val = ext_pin1_priority;
            `IPR_OFS_TMR4_OC:   rd_val = timer4_compare34_priority;
            `IPR_OFS_U2_T5:     rd_val = uart2_ext2_timer5_priority;
            `IPR_OFS_REQ_STAT:  rd_val = {2'h0, src_req_q};
            `IPR_OFS_EN_STAT:   rd_val = {2'h0, src_en};
            default:            rd_mapped = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= {`IPR_DATA_W{1'b0}};
            s_axi_rresp  <= `IPR_RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {16'h0000, rd_val};
            s_axi_rresp  <= rd_mapped ? `IPR_RESP_OKAY : `IPR_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ---- ipr_regs_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module ipr_regs_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [13:0] src_req_in,
    input wire logic [13:0] src_req_q,
    input wire logic [2:0]  converter_done_level,
    input wire logic [2:0]  timer_five_level
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    gate_first_a: assert property (
        $past(aresetn) |-> src_req_q[0] == ($past(src_req_in[0]) && $past(converter_done_level) != 3'h0))
        else $error("gated request of first source wrong");
    gate_last_a: assert property (
        $past(aresetn) |-> src_req_q[13] == ($past(src_req_in[13]) && $past(timer_five_level) != 3'h0))
        else $error("gated request of last source wrong");
    reset_level_a: assert property (
        $rose(aresetn) |-> converter_done_level == 3'h4 && timer_five_level == 3'h4)
        else $error("level not 100 after reset");
    level_hold_a: assert property (
        $past(aresetn) && !$rose(s_axi_bvalid) |-> $stable(converter_done_level) && $stable(timer_five_level))
        else $error("level changed without a write");
    upper_zero_a: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h0_0000)
        else $error("unused read bits not zero");
    write_resp_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write response late");
    read_resp_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    read_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    write_busy_a: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    resp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before taken");
    cover property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property (src_req_in[0] && converter_done_level == 3'h0);
endmodule
`default_nettype wire

// ---- interrupt_priority_regs_3_to_7_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "ipr_defines.vh"
module interrupt_priority_regs_3_to_7_tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [13:0] req = 14'h0000;
    wire         awready, wready, bvalid, arready, rvalid;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [13:0] req_q;
    wire  [2:0]  lvl [0:13];
    logic [15:0] mdl [0:4];
    int          n_errors = 0;
    int          tests_run = 0;
    localparam logic [15:0] MASK [0:4] = '{16'h0077, 16'h7777, 16'h0007, 16'h7770, 16'h7777};
    localparam logic [7:0]  OFS [0:4] = '{`IPR_OFS_ADC_UART1, `IPR_OFS_CHG_CMP, `IPR_OFS_EXT1,
                                          `IPR_OFS_TMR4_OC, `IPR_OFS_U2_T5};
    localparam int          REGI [0:13] = '{0, 0, 1, 1, 1, 1, 2, 3, 3, 3, 4, 4, 4, 4};
    localparam int          LSB [0:13] = '{4, 0, 12, 8, 4, 0, 0, 12, 8, 4, 12, 8, 4, 0};

    ipr_regs ipr_regs_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .src_req_in(req), .src_req_q(req_q),
        .converter_done_level(lvl[0]), .serial_one_send_level(lvl[1]), .pin_change_level(lvl[2]),
        .comparator_level(lvl[3]), .twowire_one_master_level(lvl[4]), .twowire_one_slave_level(lvl[5]),
        .ext_pin_one_level(lvl[6]), .timer_four_level(lvl[7]), .compare_four_level(lvl[8]),
        .compare_three_level(lvl[9]), .serial_two_send_level(lvl[10]), .serial_two_receive_level(lvl[11]),
        .ext_pin_two_level(lvl[12]), .timer_five_level(lvl[13])
    );

    initial begin
        forever #25 aclk = ~aclk;
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic stall();
        n_errors++;
        $display("ERROR handshake expected response seen none");
        conclude();
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        repeat (40) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                return;
            end
        end
        stall();
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        repeat (40) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                return;
            end
        end
        stall();
    endtask

    task automatic wr(input int r, input logic [31:0] d, input logic [3:0] s);
        logic [1:0]  rs;
        logic [15:0] m;
        m = MASK[r] & {{8{s[1]}}, {8{s[0]}}};
        axw(OFS[r], d, s, rs);
        chk("bresp", rs, `IPR_RESP_OKAY);
        mdl[r] = (mdl[r] & ~m) | (d[15:0] & m);
    endtask

    function automatic logic [31:0] exp_lvl(input int i);
        return (mdl[REGI[i]] >> LSB[i]) & 16'h0007;
    endfunction

    task automatic chk_all();
        logic [31:0] d;
        logic [1:0]  rs;
        for (int r = 0; r < 5; r++) begin
            axr(OFS[r], d, rs);
            chk("register", d, {16'h0000, mdl[r]});
            chk("rresp", rs, `IPR_RESP_OKAY);
        end
        for (int i = 0; i < 14; i++) chk("level", lvl[i], exp_lvl(i));
    endtask

    initial begin
        logic [31:0] d;
        logic [1:0]  rs;
        logic [13:0] rv;
        int          r;
        void'($urandom(32'h9452));
        for (r = 0; r < 5; r++) mdl[r] = MASK[r] & 16'h4444;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        chk_all();
        $display("Test reset values done");
        for (int i = 0; i < 30; i++) begin
            r = (i < 5) ? i : int'($urandom % 5);
            d = (i < 5) ? 32'hffff_ffff : $urandom;
            wr(r, d, (i < 5) ? 4'hf : 4'($urandom));
            chk_all();
        end
        $display("Test random writes done");
        axw(8'h40, 32'hffff_ffff, 4'hf, rs);
        chk("bresp", rs, `IPR_RESP_SLVERR);
        axw(`IPR_OFS_EN_STAT, 32'hffff_ffff, 4'hf, rs);
        chk("bresp", rs, `IPR_RESP_OKAY);
        axr(8'h40, d, rs);
        chk("rdata", d, 32'h0000_0000);
        chk("rresp", rs, `IPR_RESP_SLVERR);
        chk_all();
        $display("Test unmapped access done");
        for (int c = 0; c < 8; c++) begin
            for (r = 0; r < 5; r++) wr(r, {16'h0000, {4{1'b0, 3'(c)}}}, 4'h3);
            chk_all();
            axr(`IPR_OFS_EN_STAT, d, rs);
            chk("enabled", d, (c == 0) ? 32'h0000_0000 : 32'h0000_3fff);
            repeat (4) begin
                rv = 14'($urandom);
                @(posedge aclk);
                req <= rv;
                @(posedge aclk);
                #1;
                chk("gated", req_q, (c == 0) ? 14'h0000 : rv);
                axr(`IPR_OFS_REQ_STAT, d, rs);
                chk("req status", d, (c == 0) ? 32'h0000_0000 : {18'h0_0000, rv});
            end
        end
        $display("Test level codes done");
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (r = 0; r < 5; r++) mdl[r] = MASK[r] & 16'h4444;
        chk_all();
        wr(0, 32'h0000_0012, 4'h1);
        chk_all();
        $display("Test second reset done");
        conclude();
    end
endmodule
bind ipr_regs ipr_regs_monitor ipr_regs_monitor_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .src_req_in(src_req_in), .src_req_q(src_req_q), .converter_done_level(converter_done_level),
    .timer_five_level(timer_five_level)
);
`default_nettype wire
